/* verilog/socket_force_event_logic.sv */
// Operation
// R1 - Bits 31 to 15 of injection register read zero, writes ignored.
// R2 - Retest bit starts interrogation, refreshes present state, re-enables power control.
// R3 - Software writes retest together with any interrogation-dependent force.
// R4 - Forced card-voltage bits load the matching present-state bits.
// R5 - Any forced voltage bit set disables power control until retest.
// R6 - Forced invalid-supply bit loads the present-state flag.
// R7 - Forced data-loss bit loads the present-state flag.
// R8 - Forced unrecognised-card bit loads the present-state flag.
// R9 - Bit 6 reads zero and ignores writes.
// R10 - Forced wide-card bit loads the wide-card detected bit.
// R11 - Forced narrow-card bit loads the narrow-card detected bit.
// R12 - Forced power bit sets power event, powered status unchanged.
// R13 - Forced detect bits set detect events, live levels unchanged.
// R14 - Forced status bit sets status event, live level unchanged.
// R15 - Injection register decoded at 0x0C, resets to zero.
// R16 - Card type bits change only by interrogation or forced write.
// R17 - All write-only force bits read zero.
// R18 - Forced events reach interrupt logic like real ones.
module socket_force_event_logic (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    // Interrogation engine
    input  wire logic         interrog_done,
    input  wire logic [31:0]  interrog_present,
    output logic              interrog_start,
    // Socket side
    input  wire logic [3:0]   socket_event_in,
    output logic [31:0]       present_state,
    output logic [3:0]        socket_events,
    output logic              power_ctrl_enable,
    // Interrupt
    output logic              irq
);
    force_bus_if link ();
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0]  en_q, en_d;
    logic [3:0]  clr;
    logic        req;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; one wait state keeps read data registered
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign link.wr = req && wb_we_i && wb_adr_i == force_pkg::OFF_INJECT; // R15
    assign link.wdata = wb_dat_i & 32'h0000_7FBF; // R1 R9
    assign link.sel = wb_sel_i;
    assign clr = (req && wb_we_i && wb_adr_i == force_pkg::OFF_IRQ_CLEAR && wb_sel_i[0])
                 ? wb_dat_i[3:0] : 4'h0;

    always_comb begin
        ack_d = req;
        en_d = en_q;
        rdata_d = 32'h0000_0000;
        if (req && wb_we_i && wb_adr_i == force_pkg::OFF_IRQ_ENABLE && wb_sel_i[0]) begin
            en_d = wb_dat_i[3:0];
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                force_pkg::OFF_INJECT:     rdata_d = force_pkg::INJECT_RESET; // R17 R1
                force_pkg::OFF_IRQ_STATUS: rdata_d = {28'h0000000, link.events};
                force_pkg::OFF_IRQ_ENABLE: rdata_d = {28'h0000000, en_q};
                force_pkg::OFF_PRESENT:    rdata_d = link.present;
                force_pkg::OFF_EVENT:      rdata_d = {27'h0000000, link.volt_lock, 4'h0};
                default:                   rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            en_q    <= force_pkg::IRQ_ENABLE_RESET;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            en_q    <= en_d;
        end
    end

    force_core u_core (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .interrog_done    (interrog_done),
        .interrog_present (interrog_present),
        .socket_event_in  (socket_event_in),
        .event_clear      (clr),
        .bus              (link.core)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign interrog_start = link.retest; // R2
    assign present_state = link.present;
    assign socket_events = link.events;
    assign power_ctrl_enable = !link.volt_lock; // R5
    assign irq = |(link.events & en_q); // R18

    ack_one_a: assert property (@(posedge clk_sys) disable iff (reset)
        wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q) // R15
        else $error("ack not single cycle");
    read_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        req && !wb_we_i && wb_adr_i == 8'h0C |=> wb_dat_o == 32'h0) // R17
        else $error("injection register read nonzero");
    // A forced status event on enabled bit 0 must raise the interrupt like a real one
    irq_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        link.wr && link.wdata[0] && wb_sel_i[0] && en_q[0] |=> irq) // R18
        else $error("irq mismatch");
    wr_cov: cover property (@(posedge clk_sys) link.wr);
    irq_cov: cover property (@(posedge clk_sys) irq);
endmodule // socket_force_event_logic

/* verilog/force_pkg.sv */
package force_pkg;
    // Register map, byte addresses
    localparam logic [7:0] OFF_INJECT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h44;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h48;
    localparam logic [7:0] OFF_PRESENT = 8'h4C;
    localparam logic [7:0] OFF_EVENT = 8'h50;
    // Injection register fields
    localparam int POS_RETEST = 14;
    localparam int POS_VOLT_LO = 10;
    localparam int POS_VOLT_HI = 13;
    localparam int POS_SUPPLY = 9;
    localparam int POS_LOSS = 8;
    localparam int POS_UNREC = 7;
    localparam int POS_WIDE = 5;
    localparam int POS_NARROW = 4;
    localparam int POS_EVT_HI = 3;
    // Present-state bits the injection register may overwrite
    localparam logic [31:0] PRESENT_FORCE_MASK = 32'h0000_3FB0;
    localparam logic [31:0] INJECT_RESET = 32'h0000_0000;
    localparam logic [3:0] EVENT_RESET = 4'h0;
    localparam logic [31:0] PRESENT_RESET = 32'h0000_0000;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
endpackage

/* verilog/force_bus_if.sv */
interface force_bus_if;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  sel;
    logic [31:0] present;
    logic [3:0]  events;
    logic        retest;
    logic        volt_lock;
    modport ctl (output wr, output wdata, output sel, input present, input events,
                 input retest, input volt_lock);
    modport core (input wr, input wdata, input sel, output present, output events,
                  output retest, output volt_lock);
endinterface

/* verilog/force_core.sv */
module force_core (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  reset,
    // Interrogation result
    input  wire logic         interrog_done,
    input  wire logic [31:0]  interrog_present,
    // Real socket events
    input  wire logic [3:0]   socket_event_in,
    input  wire logic [3:0]   event_clear,
    // Link to bus side
    force_bus_if.core         bus
);
    logic [31:0] present_q, present_d;
    logic [3:0]  events_q, events_d;
    logic        lock_q, lock_d;
    logic        retest_q, retest_d;
    logic [31:0] w;

    // Only byte-enabled lanes count as written
    always_comb begin
        w = bus.wdata & {{8{bus.sel[3]}}, {8{bus.sel[2]}}, {8{bus.sel[1]}}, {8{bus.sel[0]}}};
        present_d = present_q;
        events_d = (events_q | socket_event_in) & ~event_clear;
        lock_d = lock_q;
        retest_d = 1'b0;
        if (interrog_done) begin
            present_d = interrog_present; // R16
            lock_d = 1'b0; // R2
        end
        if (bus.wr && bus.sel[1] && w[force_pkg::POS_RETEST]) begin
            retest_d = 1'b1; // R2
        end
        if (bus.wr) begin
            // Forced values override card fields; live pin bits untouched
            present_d = (present_d & ~mask_of(bus.sel)) | (w & mask_of(bus.sel)); // R4 R6 R7 R8 R10 R11
            // Forced events behave like real ones, set wins over clear
            events_d = events_d | w[force_pkg::POS_EVT_HI:0]; // R12 R13 R14 R18
            if (|w[force_pkg::POS_VOLT_HI:force_pkg::POS_VOLT_LO]) begin
                lock_d = 1'b1; // R5
            end
        end
        events_d = events_d | socket_event_in;
    end

    // Bits of present state selected by written lanes
    function automatic logic [31:0] mask_of(input logic [3:0] s);
        mask_of = force_pkg::PRESENT_FORCE_MASK
                  & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // State registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            present_q <= force_pkg::PRESENT_RESET;
            events_q  <= force_pkg::EVENT_RESET;
            lock_q    <= 1'b0;
            retest_q  <= 1'b0;
        end else begin
            present_q <= present_d;
            events_q  <= events_d;
            lock_q    <= lock_d;
            retest_q  <= retest_d;
        end
    end

    assign bus.present = present_q;
    assign bus.events = events_q;
    assign bus.retest = retest_q;
    assign bus.volt_lock = lock_q;

    // Write with card-voltage bit set locks power control next cycle
    lock_after_force_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && (|w[13:10]) |=> lock_q) // R5
        else $error("power control not locked after forced voltage");
    retest_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && bus.sel[1] && w[14] |=> retest_q ##1 !retest_q) // R2
        else $error("retest not a single pulse");
    unlock_done_a: assert property (@(posedge clk_sys) disable iff (reset)
        interrog_done && !bus.wr |=> !lock_q) // R2
        else $error("lock not released by interrogation");
    event_force_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && w[0] |=> events_q[0]) // R14
        else $error("forced status event lost");
    event_detect_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && (w[2] || w[1]) |=> (events_q[2] || events_q[1])) // R13
        else $error("forced detect event lost");
    power_event_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && w[3] && !interrog_done |=> events_q[3] && present_q[3] == $past(present_q[3])) // R12
        else $error("forced power event wrong");
    card_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
        !bus.wr && !interrog_done |=> $stable(present_q[5:4])) // R16
        else $error("card type changed spontaneously");
    force_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        bus.wr && bus.sel[0] && !interrog_done
        |=> present_q[5:4] == $past(w[5:4]) && present_q[6] == $past(present_q[6])) // R10 R11 R9
        else $error("forced card type not loaded");
    force_cov: cover property (@(posedge clk_sys) bus.wr && w[11] ##[1:20] bus.retest);
endmodule // force_core

/* tb/test_socket_force_event_logic.sv */
module test_socket_force_event_logic;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0, reset = 1'b1, interrog_done = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0, socket_event_in = 4'h0, ev;
    logic [31:0] wb_dat_i = 32'h0, interrog_present = 32'h0, v, pres;
    logic [31:0] wb_dat_o, present_state;
    logic        wb_ack_o, interrog_start, power_ctrl_enable, irq;
    logic [3:0]  socket_events;
    logic [31:0] exp_q[$];
    int          error_cnt = 0, checked = 0, cyc_cnt = 0, start_cnt = 0;

    socket_force_event_logic dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .interrog_done(interrog_done), .interrog_present(interrog_present),
        .interrog_start(interrog_start), .socket_event_in(socket_event_in),
        .present_state(present_state), .socket_events(socket_events),
        .power_ctrl_enable(power_ctrl_enable), .irq(irq));

    // 250 MHz clock
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Classic cycle held until ack; a read leaves its expected data for the monitor
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_sys);
        if (!we) exp_q.push_back(dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= we ? dat : 32'h0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 64) chk(32'h0, 32'h1, "no ack");
    endtask

    // Monitor: read data is taken only at the edge that samples ack; also the hang guard
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (interrog_start === 1'b1) start_cnt <= start_cnt + 1;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            chk(wb_dat_o, exp_q.pop_front(), "read data");
        if (cyc_cnt == 5000) begin
            chk(32'h0, 32'h1, "timeout");
            end_sim();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(69));
        pres = force_pkg::PRESENT_RESET;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        wb(1'b0, force_pkg::OFF_INJECT, 4'hF, force_pkg::INJECT_RESET);
        wb(1'b0, force_pkg::OFF_PRESENT, 4'hF, pres);
        wb(1'b1, 8'h80, 4'hF, $urandom());
        wb(1'b0, 8'h80, 4'hF, 32'h0);
        chk(power_ctrl_enable, 32'h1, "enable after reset");
        $display("test reset done");
        // Forced present-state bits, power lock and retest
        for (int i = 0; i < 8; i++) begin
            v = $urandom() & 32'hFFFF_BFF0;
            wb(1'b1, force_pkg::OFF_INJECT, 4'hF, v);
            pres = (pres & ~force_pkg::PRESENT_FORCE_MASK) | (v & force_pkg::PRESENT_FORCE_MASK);
            wb(1'b0, force_pkg::OFF_PRESENT, 4'hF, pres);
            wb(1'b0, force_pkg::OFF_INJECT, 4'hF, 32'h0);
            chk(power_ctrl_enable, {31'h0, v[13:10] == 4'h0}, "power lock");
            wb(1'b0, force_pkg::OFF_EVENT, 4'hF, {27'h0, v[13:10] != 4'h0, 4'h0});
            wb(1'b1, force_pkg::OFF_INJECT, 4'h2, 32'h0000_4000);
            @(negedge clk_sys);
            chk(start_cnt, i + 1, "retest start");
            v = $urandom();
            @(posedge clk_sys);
            interrog_done <= 1'b1;
            interrog_present <= v;
            @(posedge clk_sys);
            interrog_done <= 1'b0;
            pres = v;
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk(present_state, pres, "interrogated state");
            chk(power_ctrl_enable, 32'h1, "retest unlock");
        end
        $display("test force done");
        // Forced events: present levels kept, masked, enabled, cleared
        pres = pres & 32'hFFFF_FF4F;
        ev = 4'h0;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, force_pkg::OFF_INJECT, 4'h1, 32'h1 << i);
            ev[i] = 1'b1;
            wb(1'b0, force_pkg::OFF_IRQ_STATUS, 4'hF, {28'h0, ev});
            chk(present_state, pres, "levels kept");
        end
        chk(irq, 32'h0, "masked");
        wb(1'b1, force_pkg::OFF_IRQ_ENABLE, 4'hF, 32'h4);
        @(negedge clk_sys);
        chk(irq, 32'h1, "enabled");
        wb(1'b1, force_pkg::OFF_IRQ_CLEAR, 4'hF, 32'hF);
        wb(1'b0, force_pkg::OFF_IRQ_STATUS, 4'hF, 32'h0);
        chk(irq, 32'h0, "cleared");
        @(posedge clk_sys);
        socket_event_in <= 4'h4;
        @(posedge clk_sys);
        socket_event_in <= 4'h0;
        wb(1'b0, force_pkg::OFF_IRQ_STATUS, 4'hF, 32'h4);
        @(negedge clk_sys);
        chk(irq, 32'h1, "real event");
        $display("test events done");
        end_sim();
    end
endmodule // test_socket_force_event_logic
